// [shared/nv_access_pkg.sv]
// Constants and carrier types for the data EEPROM access controller.
// Assumes a single 100 MHz core clock and an 8-bit special function register port.
package nv_access_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_TIME_NS = 4000;
    localparam int WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYCLES   = 2;
    localparam int CNT_W         = 16;

    localparam int NV_DEPTH = 64;
    localparam int LOC_W    = 6;

    // Sector 0 special function register offsets
    localparam logic [7:0] ADDR_POINTER1_LOW  = 8'h01;
    localparam logic [7:0] ADDR_POINTER1_HIGH = 8'h02;
    localparam logic [7:0] ADDR_INDIRECT1     = 8'h03;
    localparam logic [7:0] ADDR_POINTER2_LOW  = 8'h04;
    localparam logic [7:0] ADDR_POINTER2_HIGH = 8'h05;
    localparam logic [7:0] ADDR_INDIRECT2     = 8'h06;
    localparam logic [7:0] ADDR_NV_LOCATION   = 8'h1A;
    localparam logic [7:0] ADDR_NV_BYTE       = 8'h1B;
    localparam logic [7:0] ADDR_IRQ_CTRL      = 8'h1C;

    // Sector 1 position of the control register, reached only indirectly
    localparam logic [7:0] CTRL_SECTOR = 8'h01;
    localparam logic [7:0] CTRL_OFFSET = 8'h40;

    // Control register fields
    localparam int BIT_FETCH_LAUNCH   = 0;
    localparam int BIT_FETCH_PERMIT   = 1;
    localparam int BIT_PROGRAM_LAUNCH = 2;
    localparam int BIT_PROGRAM_PERMIT = 3;
    localparam logic [7:0] CTRL_IMPL_MASK = 8'h0F;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] LOC_MASK       = 8'h3F;

    // Interrupt control register fields
    localparam int BIT_NV_MASK    = 0;
    localparam int BIT_MF_ENABLE  = 1;
    localparam int BIT_NV_PENDING = 2;
    localparam int BIT_MF_PENDING = 3;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_PROGRAM} nv_state_t;

endpackage

// [hdl/data_eeprom_access_ctrl.sv]
// Data EEPROM access controller: location, byte, pointer and control registers plus a 64x8 array.
// Assumes the core presents one register access per cycle, synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Control bits 7 to 4 read zero, writes there ignored.
// - Program permit resets zero; while zero no program cycle starts.
// - Program launch starts a cycle; hardware clears it at completion.
// - Program launch with permit clear starts no cycle; only the permit bits written with it are stored.
// - Fetch permit resets zero; while zero no fetch cycle starts.
// - Fetch launch starts a cycle; hardware clears it at completion.
// - Fetch launch with permit clear starts no cycle; only the permit bits written with it are stored.
// - Fetched byte is in the byte register when fetch launch clears.
// - Byte register holds fetched value until next fetch or a software write to it.
// - Program completion shown by launch clearing, timed by internal timer.
// - Power-on clears program permit.
// - Power-on zeroes both pointer pairs.
// - Program end sets the EEPROM pending flag and shared flag.
// - Vector request needs gate, mask, shared enable and stack not full.
// - Service clears only the shared flag; software clears EEPROM flag.
// - Array of sixty-four bytes, single-byte transfers.
// - Location register six bits; upper two read zero.
// - Control register only at sector 1 offset 40H via pointers.
module data_eeprom_access_ctrl
    import nv_access_pkg::*;
#(
    parameter int PROGRAM_CYCLES = WRITE_CYCLES
) (
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    input  wire nv_access_pkg::sfr_req_t sfr_req,
    output logic [7:0]                   sfr_rdata,
    output logic                         sfr_hit,
    input  wire logic                    global_irq_gate,
    input  wire logic                    stack_full,
    input  wire logic                    irq_service,
    input  wire logic                    power_down,
    output logic                         irq_vector_req,
    output logic                         nv_busy
);
    import nv_access_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0]       pointer1_low_reg;
    logic [7:0]       pointer1_high_reg;
    logic [7:0]       pointer2_low_reg;
    logic [7:0]       pointer2_high_reg;
    logic [LOC_W-1:0] nv_location_reg;
    logic [7:0]       nv_byte_reg;
    logic [7:0]       nv_byte_next;
    logic [3:0]       ctrl_reg;
    logic [3:0]       ctrl_next;
    logic             nv_irq_mask_bit_reg;
    logic             mf_enable_reg;
    logic             nv_irq_pending_reg;
    logic             mf_pending_reg;
    logic [7:0]       rdata_reg;
    logic             hit_reg;
    nv_state_t        state_reg;
    nv_state_t        state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [7:0]       nv_array [NV_DEPTH];

    function automatic logic is_ctrl(input logic [7:0] hi, input logic [7:0] lo);
        return (hi == CTRL_SECTOR) && (lo == CTRL_OFFSET);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    wire sel_p1l  = sfr_req.addr == ADDR_POINTER1_LOW;
    wire sel_p1h  = sfr_req.addr == ADDR_POINTER1_HIGH;
    wire sel_p2l  = sfr_req.addr == ADDR_POINTER2_LOW;
    wire sel_p2h  = sfr_req.addr == ADDR_POINTER2_HIGH;
    wire sel_loc  = sfr_req.addr == ADDR_NV_LOCATION;
    wire sel_byte = sfr_req.addr == ADDR_NV_BYTE;
    wire sel_irq  = sfr_req.addr == ADDR_IRQ_CTRL;
    wire sel_ind1 = sfr_req.addr == ADDR_INDIRECT1;
    wire sel_ind2 = sfr_req.addr == ADDR_INDIRECT2;
    wire ind_ctrl = (sel_ind1 && is_ctrl(pointer1_high_reg, pointer1_low_reg))
                 || (sel_ind2 && is_ctrl(pointer2_high_reg, pointer2_low_reg));
    wire ctrl_wr  = sfr_req.wr && ind_ctrl;

    wire [3:0] ctrl_wdata    = sfr_req.wdata[3:0] & CTRL_IMPL_MASK[3:0];
    wire       req_fetch     = ctrl_wr && ctrl_wdata[BIT_FETCH_LAUNCH];
    wire       req_program   = ctrl_wr && ctrl_wdata[BIT_PROGRAM_LAUNCH];
    wire       both_launch   = req_fetch && req_program;
    wire       start_fetch   = (state_reg == ST_IDLE) && req_fetch && !both_launch
                            && ctrl_reg[BIT_FETCH_PERMIT];
    wire       start_program = (state_reg == ST_IDLE) && req_program && !both_launch
                            && ctrl_reg[BIT_PROGRAM_PERMIT];
    wire       cnt_done      = cnt_reg == '0;
    wire       fetch_end     = (state_reg == ST_FETCH) && cnt_done;
    wire       program_end   = (state_reg == ST_PROGRAM) && cnt_done && !power_down;
    wire       op_abort      = (state_reg != ST_IDLE) && power_down;

    wire [7:0] ctrl_rd = {4'h0, ctrl_reg};
    wire [7:0] irq_rd  = {4'h0, mf_pending_reg, nv_irq_pending_reg, mf_enable_reg, nv_irq_mask_bit_reg};
    wire [7:0] rd_mux  = sel_p1l  ? pointer1_low_reg :
                         sel_p1h  ? pointer1_high_reg :
                         sel_p2l  ? pointer2_low_reg :
                         sel_p2h  ? pointer2_high_reg :
                         sel_loc  ? {2'b00, nv_location_reg} :
                         sel_byte ? nv_byte_reg :
                         sel_irq  ? irq_rd :
                         ind_ctrl ? ctrl_rd : 8'h00;
    wire       rd_hit  = sel_p1l || sel_p1h || sel_p2l || sel_p2h || sel_loc || sel_byte
                      || sel_irq || ind_ctrl;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle sequencer

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_done ? cnt_reg : cnt_reg - 1'b1;
        ctrl_next  = ctrl_reg;
        if (ctrl_wr) begin
            ctrl_next[BIT_FETCH_PERMIT]   = ctrl_wdata[BIT_FETCH_PERMIT];
            ctrl_next[BIT_PROGRAM_PERMIT] = ctrl_wdata[BIT_PROGRAM_PERMIT];
        end
        case (state_reg)
            ST_IDLE: begin
                if (start_fetch) begin
                    state_next                  = ST_FETCH;
                    cnt_next                    = CNT_W'(READ_CYCLES - 1);
                    ctrl_next[BIT_FETCH_LAUNCH] = 1'b1;
                end else if (start_program) begin
                    state_next                    = ST_PROGRAM;
                    cnt_next                      = CNT_W'(PROGRAM_CYCLES - 1);
                    ctrl_next[BIT_PROGRAM_LAUNCH] = 1'b1;
                end
            end
            ST_FETCH: begin
                if (fetch_end || op_abort) begin
                    state_next                  = ST_IDLE;
                    ctrl_next[BIT_FETCH_LAUNCH] = 1'b0;
                end
            end
            ST_PROGRAM: begin
                if (program_end || op_abort) begin
                    state_next                    = ST_IDLE;
                    ctrl_next[BIT_PROGRAM_LAUNCH] = 1'b0;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Fetch result loads on the same edge that clears the launch bit
    always_comb begin
        nv_byte_next = nv_byte_reg;
        if (sfr_req.wr && sel_byte) begin
            nv_byte_next = sfr_req.wdata;
        end
        if (fetch_end && !power_down) begin
            nv_byte_next = nv_array[nv_location_reg];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
            ctrl_reg  <= CTRL_RESET[3:0];
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            ctrl_reg  <= ctrl_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (program_end) begin
            nv_array[nv_location_reg] <= nv_byte_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pointer1_low_reg  <= 8'h00;
            pointer1_high_reg <= 8'h00;
            pointer2_low_reg  <= 8'h00;
            pointer2_high_reg <= 8'h00;
            nv_location_reg   <= '0;
            nv_byte_reg       <= 8'h00;
        end else begin
            if (sfr_req.wr && sel_p1l) pointer1_low_reg <= sfr_req.wdata;
            if (sfr_req.wr && sel_p1h) pointer1_high_reg <= sfr_req.wdata;
            if (sfr_req.wr && sel_p2l) pointer2_low_reg <= sfr_req.wdata;
            if (sfr_req.wr && sel_p2h) pointer2_high_reg <= sfr_req.wdata;
            if (sfr_req.wr && sel_loc) nv_location_reg <= LOC_W'(sfr_req.wdata & LOC_MASK);
            nv_byte_reg <= nv_byte_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flags, hardware set wins over clear

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nv_irq_mask_bit_reg <= 1'b0;
            mf_enable_reg       <= 1'b0;
            nv_irq_pending_reg  <= 1'b0;
            mf_pending_reg      <= 1'b0;
        end else begin
            if (sfr_req.wr && sel_irq) begin
                nv_irq_mask_bit_reg <= sfr_req.wdata[BIT_NV_MASK];
                mf_enable_reg       <= sfr_req.wdata[BIT_MF_ENABLE];
                nv_irq_pending_reg  <= sfr_req.wdata[BIT_NV_PENDING];
                mf_pending_reg      <= sfr_req.wdata[BIT_MF_PENDING];
            end else if (irq_service) begin
                mf_pending_reg <= 1'b0;
            end
            if (program_end) begin
                nv_irq_pending_reg <= 1'b1;
                mf_pending_reg     <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
            hit_reg   <= 1'b0;
        end else begin
            rdata_reg <= rd_mux;
            hit_reg   <= rd_hit;
        end
    end

    assign sfr_rdata      = rdata_reg;
    assign sfr_hit        = hit_reg;
    assign nv_busy        = state_reg != ST_IDLE;
    assign irq_vector_req = global_irq_gate && nv_irq_mask_bit_reg && mf_enable_reg
                         && mf_pending_reg && nv_irq_pending_reg && !stack_full;

endmodule

`default_nettype wire

// [sim/nv_access_assertions.sv]
// Port-level checker for the EEPROM access controller.
// Bound into data_eeprom_access_ctrl by the bind below; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module nv_access_checker
    import nv_access_pkg::*;
#(
    parameter int PROGRAM_CYCLES = WRITE_CYCLES
) (
    input wire logic                    ref_clk,
    input wire logic                    sys_rst,
    input wire nv_access_pkg::sfr_req_t sfr_req,
    input wire logic [7:0]              sfr_rdata,
    input wire logic                    sfr_hit,
    input wire logic                    global_irq_gate,
    input wire logic                    stack_full,
    input wire logic                    irq_service,
    input wire logic                    power_down,
    input wire logic                    irq_vector_req,
    input wire logic                    nv_busy
);
    import nv_access_pkg::*;

    logic [CNT_W-1:0] busy_cnt;

    // Length of the current busy stretch
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) busy_cnt <= '0;
        else busy_cnt <= nv_busy ? busy_cnt + 1'b1 : '0;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_irq_gate_stack: assert property (irq_vector_req |-> global_irq_gate && !stack_full)
        else $error("vector request without gate or with full stack");
    a_ctrl_upper_zero: assert property (sfr_req.addr == ADDR_INDIRECT1 ##1 sfr_hit |-> sfr_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    a_unmapped_zero: assert property (!sfr_hit |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_loc_upper_zero: assert property (sfr_req.addr == ADDR_NV_LOCATION |=> sfr_rdata[7:6] == 2'h0)
        else $error("location upper bits not zero");
    a_launch_needs_write: assert property ($rose(nv_busy) |-> $past(sfr_req.wr))
        else $error("cycle started without a write");
    a_cycle_length: assert property ($fell(nv_busy) && !$past(power_down) |->
        busy_cnt == READ_CYCLES || busy_cnt == PROGRAM_CYCLES)
        else $error("cycle length wrong");
    a_sleep_abort: assert property (nv_busy && power_down |=> !nv_busy)
        else $error("cycle kept running in sleep");
    a_service_clears: assert property (irq_service && !nv_busy && !sfr_req.wr |=> !irq_vector_req)
        else $error("vector request after service");
    a_byte_holds: assert property ((sfr_req.addr == ADDR_NV_BYTE && !sfr_req.wr && !nv_busy) [*2] |=>
        $stable(sfr_rdata))
        else $error("byte register changed while idle");
endmodule
////////////////////////////////////////////////////////////
bind data_eeprom_access_ctrl nv_access_checker #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .global_irq_gate(global_irq_gate), .stack_full(stack_full), .irq_service(irq_service),
    .power_down(power_down), .irq_vector_req(irq_vector_req), .nv_busy(nv_busy));
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the EEPROM access controller.
// Needs the package, design and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import nv_access_pkg::*;
    sfr_req_t   req;
    logic       ref_clk, sys_rst, hit, gate, full, svc, pdn, vec, busy;
    logic [7:0] rdata, v;
    int         err_count = 0, n_tests = 0, cycles = 0;
    logic [7:0] regs [7] = '{ADDR_POINTER1_LOW, ADDR_POINTER1_HIGH, ADDR_POINTER2_LOW,
                             ADDR_POINTER2_HIGH, ADDR_NV_LOCATION, ADDR_NV_BYTE, ADDR_IRQ_CTRL};

    data_eeprom_access_ctrl #(.PROGRAM_CYCLES(5)) dut (
        .ref_clk        (ref_clk),
        .sys_rst        (sys_rst),
        .sfr_req        (req),
        .sfr_rdata      (rdata),
        .sfr_hit        (hit),
        .global_irq_gate(gate),
        .stack_full     (full),
        .irq_service    (svc),
        .power_down     (pdn),
        .irq_vector_req (vec),
        .nv_busy        (busy)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One write strobe, then one idle cycle so the strobe never toggles twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{addr: a, wr: 1'b1, wdata: d};
        @(posedge ref_clk);
        #1 req.wr = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req.addr = a;
        @(posedge ref_clk);
        #1 d = rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    // Poll the control register until the given launch bit drops
    task automatic wait_clr(input logic [7:0] m);
        for (int i = 0; i < 20; i++) begin
            rd(ADDR_INDIRECT1, v);
            if ((v & m) == 8'h00) break;
        end
        chk(v & m, 8'h00);
    endtask
    task automatic prog(input logic [7:0] a, input logic [7:0] d);
        wr(ADDR_NV_LOCATION, a);
        wr(ADDR_NV_BYTE, d);
        wr(ADDR_INDIRECT1, 8'h08);
        wr(ADDR_INDIRECT1, 8'h0C);
    endtask
    task automatic fetch(input logic [7:0] a, input logic [7:0] exp);
        wr(ADDR_NV_LOCATION, a);
        wr(ADDR_INDIRECT1, 8'h02);
        wr(ADDR_INDIRECT1, 8'h03);
        wait_clr(8'h01);
        rc(ADDR_NV_BYTE, exp);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////
    initial begin
        req = '0;
        {gate, full, svc, pdn} = 4'h0;
        sys_rst = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        rc(ADDR_INDIRECT1, 8'h00);
        chk({7'h00, hit}, 8'h00);
        foreach (regs[i]) rc(regs[i], 8'h00);
        wr(ADDR_POINTER1_LOW, CTRL_OFFSET);
        wr(ADDR_POINTER1_HIGH, CTRL_SECTOR);
        rc(ADDR_INDIRECT1, CTRL_RESET);
        wr(ADDR_INDIRECT1, 8'hF0);
        rc(ADDR_INDIRECT1, 8'h00);
        wr(ADDR_INDIRECT1, 8'h04);
        rc(ADDR_INDIRECT1, 8'h00);
        wr(ADDR_INDIRECT1, 8'h01);
        rc(ADDR_INDIRECT1, 8'h00);
        rc(ADDR_NV_BYTE, 8'h00);
        wr(ADDR_NV_LOCATION, 8'hFF);
        rc(ADDR_NV_LOCATION, 8'h3F);
        prog(8'h00, 8'hA5);
        rc(ADDR_INDIRECT1, 8'h0C);
        chk({7'h00, busy}, 8'h01);
        wait_clr(8'h04);
        rc(ADDR_INDIRECT1, 8'h08);
        chk({7'h00, busy}, 8'h00);
        rc(ADDR_IRQ_CTRL, 8'h0C);
        wr(ADDR_IRQ_CTRL, 8'h03);
        prog(8'h3F, 8'h5A);
        gate = 1'b1;
        wait_clr(8'h04);
        chk({7'h00, vec}, 8'h01);
        full = 1'b1;
        @(posedge ref_clk);
        #1 chk({7'h00, vec}, 8'h00);
        full = 1'b0;
        svc = 1'b1;
        @(posedge ref_clk);
        #1 svc = 1'b0;
        chk({7'h00, vec}, 8'h00);
        rc(ADDR_IRQ_CTRL, 8'h07);
        fetch(8'h00, 8'hA5);
        fetch(8'h3F, 8'h5A);
        wr(ADDR_NV_LOCATION, 8'h00);
        rc(ADDR_NV_BYTE, 8'h5A);
        rc(ADDR_NV_BYTE, 8'h5A);
        wr(ADDR_IRQ_CTRL, 8'h00);
        gate = 1'b0;
        prog(8'h00, 8'h33);
        pdn = 1'b1;
        @(posedge ref_clk);
        #1 pdn = 1'b0;
        rc(ADDR_INDIRECT1, 8'h08);
        chk({7'h00, busy}, 8'h00);
        rc(ADDR_IRQ_CTRL, 8'h00);
        fetch(8'h00, 8'hA5);
        wr(ADDR_POINTER2_LOW, CTRL_OFFSET);
        wr(ADDR_POINTER2_HIGH, CTRL_SECTOR);
        rc(ADDR_INDIRECT2, 8'h02);
        wr(ADDR_POINTER1_HIGH, 8'h00);
        rc(ADDR_INDIRECT1, 8'h00);
        chk({7'h00, hit}, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
